// >>> rtl/fault_status_registers.sv
// Read-to-clear short-to-supply and global error status registers.
// Assumes detector inputs and read strobe are synchronous to i_mclk.
`timescale 1ns/1ps
module fault_status_registers (
  input  wire logic       i_mclk,
  input  wire logic       i_rst_b,
  input  wire logic       i_ce,
  input  wire logic       i_rd_en,
  input  wire logic [7:0] i_rd_addr,
  input  wire logic [3:0] i_channel_high_side_mode,
  input  wire logic [3:0] i_channel_switch_on,
  input  wire logic [3:0] i_channel_supply_short_det,
  input  wire logic       i_fault_latch_enable,
  input  wire logic [1:0] i_serial_watchdog_timeout_select,
  input  wire logic       i_sync_watchdog_enable,
  input  wire logic       i_serial_watchdog_expired,
  input  wire logic       i_sync_watchdog_expired,
  input  wire logic       i_ground_loss_det,
  input  wire logic       i_thermal_shutdown_det,
  input  wire logic       i_main_supply_lockout_det,
  input  wire logic       i_supply_warning_det,
  input  wire logic       i_supply_low_det,
  input  wire logic       i_logic_supply_lockout_det,
  input  wire logic       i_internal_supply_lost_det,
  input  wire logic       i_supply_fault_summary_disable,
  output logic [7:0]      o_rd_data,
  output logic            o_rd_valid,
  output logic [7:0]      o_global_error_flags,
  output logic [7:0]      o_channel_supply_short_flags,
  output logic            o_communication_error_summary,
  output logic            o_supply_error_summary,
  output logic            o_overload_fault_summary
);

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  logic rd_ch;
  logic rd_gl;

  assign rd_ch = i_rd_en &
                 (i_rd_addr == fault_status_pkg::ADDR_CHANNEL_SUPPLY_SHORT_FLAGS);
  assign rd_gl = i_rd_en &
                 (i_rd_addr == fault_status_pkg::ADDR_GLOBAL_ERROR_FLAGS);

  // ----------------------------------------------------------------
  // Fault conditions
  // ----------------------------------------------------------------
  logic [3:0] ch_cond;
  logic [7:0] gl_cond;
  logic [3:0] ch_flag;
  logic [7:0] gl_flag;
  logic       serial_wd_on;

  assign serial_wd_on = i_serial_watchdog_timeout_select !=
                        fault_status_pkg::SERIAL_WATCHDOG_OFF;

  // Short seen only in high-side mode with switch off
  assign ch_cond = i_channel_high_side_mode & ~i_channel_switch_on &
                   i_channel_supply_short_det;

  // Either enabled watchdog timing out
  assign gl_cond[fault_status_pkg::GE_WATCHDOG_TIMEOUT] =
    (serial_wd_on & i_serial_watchdog_expired) |
    (i_sync_watchdog_enable & i_sync_watchdog_expired);
  // Ground loss detector
  assign gl_cond[fault_status_pkg::GE_GROUND_LOSS] = i_ground_loss_det;
  // Thermal shutdown detector
  assign gl_cond[fault_status_pkg::GE_THERMAL_SHUTDOWN] =
    i_thermal_shutdown_det;
  // Supply monitors
  assign gl_cond[fault_status_pkg::GE_MAIN_SUPPLY_LOCKOUT] =
    i_main_supply_lockout_det;
  assign gl_cond[fault_status_pkg::GE_SUPPLY_WARNING] = i_supply_warning_det;
  assign gl_cond[fault_status_pkg::GE_SUPPLY_LOW] = i_supply_low_det;
  assign gl_cond[fault_status_pkg::GE_LOGIC_SUPPLY_LOCKOUT] =
    i_logic_supply_lockout_det;
  // Internal supply monitor
  assign gl_cond[fault_status_pkg::GE_INTERNAL_SUPPLY_LOST] =
    i_internal_supply_lost_det;

  // ----------------------------------------------------------------
  // Flag cells
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < fault_status_pkg::CH_COUNT; gi = gi + 1) begin : g_ch
      // Channel i at bit i, latch mode selectable
      rc_flag_cell #(
        .RESET_VALUE (fault_status_pkg::CHANNEL_SHORT_RESET[gi])
      ) u_cell (
        .i_mclk   (i_mclk),
        .i_rst_b  (i_rst_b),
        .i_ce     (i_ce),
        .i_latch  (i_fault_latch_enable),
        .i_cond   (ch_cond[gi]),
        .i_rd_clr (rd_ch),
        .o_flag   (ch_flag[gi])
      );
    end
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_gl
      // Always latched; ground loss resets to 0
      rc_flag_cell #(
        .RESET_VALUE (fault_status_pkg::GLOBAL_ERROR_RESET[gi])
      ) u_cell (
        .i_mclk   (i_mclk),
        .i_rst_b  (i_rst_b),
        .i_ce     (i_ce),
        .i_latch  (1'b1),
        .i_cond   (gl_cond[gi]),
        .i_rd_clr (rd_gl),
        .o_flag   (gl_flag[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;
  logic       rd_valid_reg;
  logic       rd_valid_next;
  logic [7:0] gl_out_reg;
  logic [7:0] ch_out_reg;
  logic [7:0] ch_out_next;
  logic       comm_reg;
  logic       comm_next;
  logic       supply_reg;
  logic       supply_next;
  logic       overload_reg;
  logic       overload_next;

  always_comb begin
    rd_valid_next = i_rd_en;
    ch_out_next   = {4'h0, ch_flag};
    // Read data is the value held before the clear
    if (rd_ch) begin
      rd_data_next = ch_out_next;
    end else if (rd_gl) begin
      rd_data_next = gl_flag;
    end else begin
      rd_data_next = fault_status_pkg::READ_IDLE_DATA;
    end
    // Communication error summary
    comm_next = gl_flag[fault_status_pkg::GE_WATCHDOG_TIMEOUT];
    // Supply error summary
    supply_next = gl_flag[fault_status_pkg::GE_GROUND_LOSS] |
                  (~i_supply_fault_summary_disable &
                   (gl_flag[fault_status_pkg::GE_MAIN_SUPPLY_LOCKOUT] |
                    gl_flag[fault_status_pkg::GE_SUPPLY_WARNING] |
                    gl_flag[fault_status_pkg::GE_SUPPLY_LOW]));
    // Overload fault summary
    overload_next = gl_flag[fault_status_pkg::GE_THERMAL_SHUTDOWN];
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      rd_data_reg  <= fault_status_pkg::READ_IDLE_DATA;
      rd_valid_reg <= 1'b0;
      gl_out_reg   <= fault_status_pkg::GLOBAL_ERROR_RESET;
      ch_out_reg   <= 8'h00;
      comm_reg     <= 1'b0;
      supply_reg   <= 1'b0;
      overload_reg <= 1'b0;
    end else if (i_ce) begin
      rd_data_reg  <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
      gl_out_reg   <= gl_flag;
      ch_out_reg   <= ch_out_next;
      comm_reg     <= comm_next;
      supply_reg   <= supply_next;
      overload_reg <= overload_next;
    end
  end

  assign o_rd_data                     = rd_data_reg;
  assign o_rd_valid                    = rd_valid_reg;
  assign o_global_error_flags          = gl_out_reg;
  assign o_channel_supply_short_flags  = ch_out_reg;
  assign o_communication_error_summary = comm_reg;
  assign o_supply_error_summary        = supply_reg;
  assign o_overload_fault_summary      = overload_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_channel_map;
    @(posedge i_mclk) disable iff (!i_rst_b)
      i_ce |=> o_channel_supply_short_flags == {4'h0, $past(ch_flag)};
  endproperty
  a_channel_map: assert property (p_channel_map)
    else $error("channel short flags misplaced");

  property p_short_needs_hs;
    @(posedge i_mclk) disable iff (!i_rst_b)
      (i_ce && !i_fault_latch_enable && !i_channel_high_side_mode[2])
      |=> !ch_flag[2];
  endproperty
  a_short_needs_hs: assert property (p_short_needs_hs)
    else $error("short flag set outside high-side mode");

  property p_realtime;
    @(posedge i_mclk) disable iff (!i_rst_b)
      (i_ce && !i_fault_latch_enable) |=> ch_flag == $past(ch_cond);
  endproperty
  a_realtime: assert property (p_realtime)
    else $error("real-time short flag does not follow detector");

  property p_latched_hold;
    @(posedge i_mclk) disable iff (!i_rst_b)
      (i_ce && i_fault_latch_enable && ch_flag[1] && !rd_ch)
      |=> ch_flag[1];
  endproperty
  a_latched_hold: assert property (p_latched_hold)
    else $error("latched short flag lost without a read");

  property p_global_clear;
    @(posedge i_mclk) disable iff (!i_rst_b)
      (i_ce && rd_gl) |=> gl_flag == $past(gl_cond);
  endproperty
  a_global_clear: assert property (p_global_clear)
    else $error("global read did not clear stale flags");

  property p_global_hold;
    @(posedge i_mclk) disable iff (!i_rst_b)
      (i_ce && !rd_gl) |=> (gl_flag & $past(gl_flag)) == $past(gl_flag);
  endproperty
  a_global_hold: assert property (p_global_hold)
    else $error("global flag cleared without a read");

  property p_watchdog_set;
    @(posedge i_mclk) disable iff (!i_rst_b)
      (i_ce && serial_wd_on && i_serial_watchdog_expired)
      |=> gl_flag[fault_status_pkg::GE_WATCHDOG_TIMEOUT];
  endproperty
  a_watchdog_set: assert property (p_watchdog_set)
    else $error("watchdog timeout not flagged");

  property p_watchdog_disabled;
    @(posedge i_mclk) disable iff (!i_rst_b)
      (i_ce && rd_gl && !serial_wd_on && !i_sync_watchdog_enable)
      |=> !gl_flag[fault_status_pkg::GE_WATCHDOG_TIMEOUT];
  endproperty
  a_watchdog_disabled: assert property (p_watchdog_disabled)
    else $error("watchdog flag set while watchdogs disabled");

  property p_comm_summary;
    @(posedge i_mclk) disable iff (!i_rst_b)
      i_ce |=> o_communication_error_summary ==
               $past(gl_flag[fault_status_pkg::GE_WATCHDOG_TIMEOUT]);
  endproperty
  a_comm_summary: assert property (p_comm_summary)
    else $error("communication summary wrong");

  property p_supply_summary;
    @(posedge i_mclk) disable iff (!i_rst_b)
      (i_ce && gl_flag[fault_status_pkg::GE_GROUND_LOSS])
      |=> o_supply_error_summary;
  endproperty
  a_supply_summary: assert property (p_supply_summary)
    else $error("ground loss missing from supply summary");

  property p_supply_disable;
    @(posedge i_mclk) disable iff (!i_rst_b)
      (i_ce && i_supply_fault_summary_disable)
      |=> o_supply_error_summary ==
          $past(gl_flag[fault_status_pkg::GE_GROUND_LOSS]);
  endproperty
  a_supply_disable: assert property (p_supply_disable)
    else $error("supply summary not gated by disable");

  property p_overload_summary;
    @(posedge i_mclk) disable iff (!i_rst_b)
      i_ce |=> o_overload_fault_summary ==
               $past(gl_flag[fault_status_pkg::GE_THERMAL_SHUTDOWN]);
  endproperty
  a_overload_summary: assert property (p_overload_summary)
    else $error("overload summary wrong");

  property p_read_sample;
    @(posedge i_mclk) disable iff (!i_rst_b)
      (i_ce && rd_gl) |=> o_rd_data == $past(gl_flag) && o_rd_valid;
  endproperty
  a_read_sample: assert property (p_read_sample)
    else $error("read data not the pre-clear value");

endmodule

// >>> rtl/fault_status_pkg.sv
// Constants shared by the fault status register bank.
// Assumes a single 50 MHz system clock and a synchronous active-low reset.
package fault_status_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CHANNEL_SUPPLY_SHORT_FLAGS = 8'h06;
  localparam logic [7:0] ADDR_GLOBAL_ERROR_FLAGS         = 8'h07;

  // ----------------------------------------------------------------
  // Field positions of global_error_flags
  // ----------------------------------------------------------------
  localparam int GE_WATCHDOG_TIMEOUT    = 7;
  localparam int GE_GROUND_LOSS         = 6;
  localparam int GE_THERMAL_SHUTDOWN    = 5;
  localparam int GE_MAIN_SUPPLY_LOCKOUT = 4;
  localparam int GE_SUPPLY_WARNING      = 3;
  localparam int GE_SUPPLY_LOW          = 2;
  localparam int GE_LOGIC_SUPPLY_LOCKOUT = 1;
  localparam int GE_INTERNAL_SUPPLY_LOST = 0;

  // ----------------------------------------------------------------
  // Field positions of channel_supply_short_flags
  // ----------------------------------------------------------------
  localparam int CH_SUPPLY_SHORT_LSB = 0;
  localparam int CH_COUNT            = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] GLOBAL_ERROR_RESET  = 8'h1F;
  localparam logic [3:0] CHANNEL_SHORT_RESET = 4'h0;
  localparam logic [7:0] READ_IDLE_DATA      = 8'h00;
  localparam logic [1:0] SERIAL_WATCHDOG_OFF = 2'h0;

endpackage

// >>> rtl/rc_flag_cell.sv
// One read-to-clear status flag, real time or latched.
// Assumes the condition input is synchronous to i_mclk.
`timescale 1ns/1ps
module rc_flag_cell #(
  parameter logic RESET_VALUE = 1'b0
) (
  input  wire logic i_mclk,
  input  wire logic i_rst_b,
  input  wire logic i_ce,
  input  wire logic i_latch,
  input  wire logic i_cond,
  input  wire logic i_rd_clr,
  output logic      o_flag
);

  logic flag_reg;
  logic flag_next;

  // ----------------------------------------------------------------
  // Next flag value
  // ----------------------------------------------------------------
  always_comb begin
    if (!i_latch) begin
      flag_next = i_cond;
    end else if (i_rd_clr) begin
      flag_next = i_cond;
    end else begin
      flag_next = i_cond | flag_reg;
    end
  end

  // ----------------------------------------------------------------
  // Flag register
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      flag_reg <= RESET_VALUE;
    end else if (i_ce) begin
      flag_reg <= flag_next;
    end
  end

  assign o_flag = flag_reg;

endmodule

// >>> tb/host_reader.sv
// Host model that issues single-cycle register reads.
// Assumes the bank answers one cycle after each taken read.
`timescale 1ns/1ps
module host_reader (
  input  wire logic       i_mclk,
  input  wire logic [7:0] i_rd_data,
  input  wire logic       i_rd_valid,
  output logic            o_rd_en,
  output logic [7:0]      o_rd_addr
);
  logic seen_global = 1'h0;

  initial begin
    o_rd_en   = 1'h0;
    o_rd_addr = 8'hA5;
  end

  // ----------------------------------------------------------------
  // Read-to-clear pulse, address inverted once released
  // ----------------------------------------------------------------
  task automatic do_read(input logic [7:0] a, output logic [7:0] d,
                         output logic ok);
    @(posedge i_mclk);
    #1;
    o_rd_en = 1'h1;
    o_rd_addr = a;
    @(posedge i_mclk);
    #1;
    o_rd_en = 1'h0;
    o_rd_addr = ~a;
    ok = i_rd_valid;
    d = i_rd_data;
    // Record that at least one global read has been issued
    if (a == fault_status_pkg::ADDR_GLOBAL_ERROR_FLAGS) begin
      seen_global = 1'h1;
    end
  endtask
endmodule

// >>> tb/fault_status_registers_tb_top.sv
// Self-checking bench for the fault status register bank.
// Assumes host_reader drives the read port and times every read.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %s expected %h seen %h", nm, e, g); end end
module fault_status_registers_tb_top;
  logic       i_mclk = 1'h0;
  logic       i_rst_b = 1'h0;
  logic       i_ce = 1'h1;
  logic       i_rd_en;
  logic [7:0] i_rd_addr, o_rd_data, o_global_error_flags, gv = 8'h00;
  logic [7:0] o_channel_supply_short_flags;
  logic [3:0] i_channel_high_side_mode = 4'h0, i_channel_switch_on = 4'h0;
  logic [3:0] i_channel_supply_short_det = 4'h0;
  logic [1:0] i_serial_watchdog_timeout_select = 2'h0;
  logic       i_fault_latch_enable = 1'h0, i_sync_watchdog_enable = 1'h0;
  logic       i_sync_watchdog_expired = 1'h0;
  logic       i_supply_fault_summary_disable = 1'h0;
  logic       i_serial_watchdog_expired, i_ground_loss_det;
  logic       i_thermal_shutdown_det, i_main_supply_lockout_det;
  logic       i_supply_warning_det, i_supply_low_det;
  logic       i_logic_supply_lockout_det, i_internal_supply_lost_det;
  logic       o_rd_valid, o_communication_error_summary;
  logic       o_supply_error_summary, o_overload_fault_summary;
  int         bad_count = 0, n_tests = 0, cyc = 0;

  assign {i_serial_watchdog_expired, i_ground_loss_det,
          i_thermal_shutdown_det, i_main_supply_lockout_det,
          i_supply_warning_det, i_supply_low_det,
          i_logic_supply_lockout_det, i_internal_supply_lost_det} = gv;

  fault_status_registers fault_status_registers_inst (
    .i_mclk, .i_rst_b, .i_ce, .i_rd_en, .i_rd_addr,
    .i_channel_high_side_mode, .i_channel_switch_on,
    .i_channel_supply_short_det, .i_fault_latch_enable,
    .i_serial_watchdog_timeout_select, .i_sync_watchdog_enable,
    .i_serial_watchdog_expired, .i_sync_watchdog_expired,
    .i_ground_loss_det, .i_thermal_shutdown_det,
    .i_main_supply_lockout_det, .i_supply_warning_det, .i_supply_low_det,
    .i_logic_supply_lockout_det, .i_internal_supply_lost_det,
    .i_supply_fault_summary_disable, .o_rd_data, .o_rd_valid,
    .o_global_error_flags, .o_channel_supply_short_flags,
    .o_communication_error_summary, .o_supply_error_summary,
    .o_overload_fault_summary
  );
  host_reader host_reader_inst (
    .i_mclk, .i_rd_data(o_rd_data), .i_rd_valid(o_rd_valid),
    .o_rd_en(i_rd_en), .o_rd_addr(i_rd_addr)
  );

  // ----------------------------------------------------------------
  // Clock, timeout, helpers
  // ----------------------------------------------------------------
  always #10 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      close_out();
    end
  end

  function automatic logic [7:0] exp_short(logic [3:0] hs, sw, det);
    return {4'h0, det & hs & ~sw};
  endfunction
  function automatic logic exp_supply(logic [7:0] g, logic dis);
    return g[6] | (~dis & (|g[4:2]));
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       ok;
    host_reader_inst.do_read(a, d, ok);
    `CHK("rd_valid", 1'h1, ok)
    `CHK("rd_data", e, d)
  endtask
  task automatic fin(input string nm);
    $display("test %s done", nm);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] e;
    logic [3:0] hs, sw, dt;
    void'($urandom(32'hBB35));
    step(20);
    i_rst_b = 1'h1;
    `CHK("ge_rst", 8'h1F, o_global_error_flags)
    step(2);
    `CHK("sup_rst", 1'h1, o_supply_error_summary)
    rd(8'h07, 8'h1F);
    rd(8'h07, 8'h00);
    fin("reset");
    for (int b = 0; b < 8; b++) begin
      i_supply_fault_summary_disable = b[0];
      i_serial_watchdog_timeout_select = 2'h1 + 2'($urandom_range(2));
      gv[b] = 1'h1;
      step(1);
      gv = 8'h00;
      step(2);
      e = 8'h01 << b;
      `CHK("ge_out", e, o_global_error_flags)
      `CHK("sup", exp_supply(e, b[0]), o_supply_error_summary)
      `CHK("ovl", e[5], o_overload_fault_summary)
      `CHK("com", e[7], o_communication_error_summary)
      rd(8'h07, e);
      rd(8'h07, 8'h00);
    end
    i_serial_watchdog_timeout_select = 2'h0;
    gv[7] = 1'h1;
    i_sync_watchdog_expired = 1'h1;
    step(3);
    `CHK("wd_off", 1'h0, o_global_error_flags[7])
    gv = 8'h00;
    i_sync_watchdog_enable = 1'h1;
    step(3);
    `CHK("wd_sync", 1'h1, o_communication_error_summary)
    i_sync_watchdog_expired = 1'h0;
    i_sync_watchdog_enable = 1'h0;
    rd(8'h07, 8'h80);
    rd(8'h07, 8'h00);
    gv[5] = 1'h1;
    step(1);
    rd(8'h07, 8'h20);
    rd(8'h07, 8'h20);
    gv = 8'h00;
    rd(8'h07, 8'h20);
    gv[6] = 1'h1;
    step(1);
    gv = 8'h00;
    rd(8'h3C, 8'h00);
    rd(8'h07, 8'h40);
    fin("global");
    for (int k = 0; k < 24; k++) begin
      hs = 4'($urandom());
      sw = (k == 0) ? 4'h0 : 4'($urandom());
      dt = (k == 0) ? 4'hF : 4'($urandom());
      i_channel_high_side_mode = hs;
      i_channel_switch_on = sw;
      i_channel_supply_short_det = dt;
      step(2);
      `CHK("ch_rt", exp_short(hs, sw, dt), o_channel_supply_short_flags)
    end
    rd(8'h06, exp_short(hs, sw, dt));
    i_channel_supply_short_det = 4'h0;
    step(2);
    `CHK("ch_gone", 8'h00, o_channel_supply_short_flags)
    i_fault_latch_enable = 1'h1;
    i_channel_high_side_mode = 4'hF;
    i_channel_switch_on = 4'h0;
    i_channel_supply_short_det = 4'h9;
    step(1);
    i_channel_supply_short_det = 4'h0;
    step(3);
    `CHK("ch_lat", 8'h09, o_channel_supply_short_flags)
    i_channel_supply_short_det = 4'h2;
    rd(8'h06, 8'h0B);
    rd(8'h06, 8'h02);
    i_channel_supply_short_det = 4'h0;
    rd(8'h06, 8'h02);
    rd(8'h06, 8'h00);
    fin("channel");
    close_out();
  end
endmodule
